/* design/erg_pkg.sv */
// Shared constants and types of the event report gate
package erg_pkg;

  localparam int NEV = 32;
  localparam int EVW = 5;

  // Register offsets
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h08;
  localparam logic [7:0] OFS_COND_STATE = 8'h0C;
  localparam logic [7:0] OFS_CONN_BASE  = 8'h10;

  // Interrupt status bits
  localparam int IRQ_ACCEPT  = 0;
  localparam int IRQ_REJECT  = 1;
  localparam int IRQ_WELCOME = 2;
  localparam int IRQ_REPORT  = 3;
  localparam int IRQ_W       = 4;

  // Event indices
  localparam int EV_BUILDING      = 0;
  localparam int EV_GROW_PRESS    = 1;
  localparam int EV_BYPASS        = 2;
  localparam int EV_CUE0          = 3;
  localparam int EV_MEM_EMPTY     = 11;
  localparam int EV_MEM_FULL      = 12;
  localparam int EV_MEM_SAFE      = 13;
  localparam int EV_MEM_UNSAFE    = 14;
  localparam int EV_DISCARD_PRESS = 15;
  localparam int EV_JUST_EMPTIED  = 16;
  localparam int EV_EXITING       = 17;
  localparam int EV_FLAG0         = 18;
  localparam int EV_JUST_FILLED   = 26;
  localparam int EV_MUTED         = 27;
  localparam int EV_LAMP0         = 28;

  // Momentary events carry no value suffix
  localparam logic [31:0] MOMENTARY_MASK = 32'h07FD87FA;

  // Reset values
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 4'h0;

  // Characters and keywords
  localparam logic [7:0]  CH_LF      = 8'h0A;
  localparam logic [7:0]  CH_CR      = 8'h0D;
  localparam logic [7:0]  CH_SP      = 8'h20;
  localparam logic [7:0]  CH_AT      = 8'h40;
  localparam logic [7:0]  CH_OK      = 8'h21;
  localparam logic [7:0]  CH_FAIL    = 8'h3F;
  localparam logic [7:0]  CH_EQ      = 8'h3D;
  localparam logic [7:0]  CH_ZERO    = 8'h30;
  localparam logic [7:0]  CH_NINE    = 8'h39;
  localparam logic [7:0]  CH_E       = 8'h65;
  localparam logic [7:0]  CH_R       = 8'h72;
  localparam logic [47:0] KW_ENABLE  = 48'h656E61626C65;
  localparam logic [55:0] KW_DISABLE = 56'h64697361626C65;
  localparam logic [23:0] KW_ALL_A   = 24'h416C6C;
  localparam logic [23:0] KW_ALL_B   = 24'h414C4C;
  localparam logic [71:0] WELCOME_TXT = 72'h4057656C636F6D6520;
  localparam logic [3:0]  WELCOME_LEN = 4'h9;

  typedef enum logic [3:0] {
    ERG_MSG_OK      = 4'b0001,
    ERG_MSG_FAIL    = 4'b0010,
    ERG_MSG_WELCOME = 4'b0100,
    ERG_MSG_EVENT   = 4'b1000
  } erg_msg_type;

  typedef enum logic [1:0] {
    ERG_P_CMD = 2'b01,
    ERG_P_ARG = 2'b10
  } erg_parse_type;

  typedef enum logic [1:0] {
    ERG_F_IDLE = 2'b01,
    ERG_F_SEND = 2'b10
  } erg_fmt_type;

endpackage

/* design/erg_msg_if.sv */
// Message request channel between the interpreter and the formatter
`timescale 1ns/1ns
interface erg_msg_if #(parameter int CW = 1);
  logic                 req_valid;
  logic                 req_ready;
  erg_pkg::erg_msg_type req_kind;
  logic [CW-1:0]        req_conn;
  logic [4:0]           req_event;
  logic                 req_has_value;
  logic                 req_value;

  modport src (output req_valid, req_kind, req_conn, req_event, req_has_value, req_value, input req_ready);
  modport dst (input req_valid, req_kind, req_conn, req_event, req_has_value, req_value, output req_ready);
endinterface

/* design/erg_cond_sync.sv */
// Condition synchroniser, memory level decode and change detection
`timescale 1ns/1ns
module erg_cond_sync #(
  parameter int NEV = 32
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic [NEV-1:0] cond_raw,
  output logic      [NEV-1:0] cond_level,
  output logic      [NEV-1:0] cond_change
);

  typedef struct packed {
    logic [NEV-1:0] s1;
    logic [NEV-1:0] s2;
    logic [NEV-1:0] lvl;
    logic [NEV-1:0] chg;
  } erg_sync_state_type;

  erg_sync_state_type r;
  erg_sync_state_type n;
  logic [NEV-1:0]     dec;

  initial
  begin
    if (NEV != erg_pkg::NEV)
      $error("erg_cond_sync: NEV must match the package");
  end

  always_comb
  begin
    n = r;
    n.s1 = cond_raw;
    n.s2 = r.s1;
    dec = r.s2;
    // Fill code on the empty/full pair, four memory conditions
    dec[erg_pkg::EV_MEM_EMPTY]  = (r.s2[erg_pkg::EV_MEM_FULL:erg_pkg::EV_MEM_EMPTY] == 2'h0);
    dec[erg_pkg::EV_MEM_UNSAFE] = (r.s2[erg_pkg::EV_MEM_FULL:erg_pkg::EV_MEM_EMPTY] == 2'h1);
    dec[erg_pkg::EV_MEM_SAFE]   = r.s2[erg_pkg::EV_MEM_FULL];
    dec[erg_pkg::EV_MEM_FULL]   = (r.s2[erg_pkg::EV_MEM_FULL:erg_pkg::EV_MEM_EMPTY] == 2'h3);
    n.lvl = dec;
    // Momentary: rising edge; state: either edge
    n.chg = (erg_pkg::MOMENTARY_MASK & dec & ~r.lvl) | (~erg_pkg::MOMENTARY_MASK & (dec ^ r.lvl));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign cond_level  = r.lvl;
  assign cond_change = r.chg;

endmodule

/* design/erg_fmt.sv */
// Output line formatter: greeting, result and event lines
`timescale 1ns/1ns
module erg_fmt #(
  parameter int          CW            = 1,
  parameter logic [15:0] SERIAL_NUMBER = 16'h0000
) (
  input  wire logic    pclk,
  input  wire logic    presetn,
  erg_msg_if.dst       msg,
  output logic         tx_valid,
  output logic [7:0]   tx_byte,
  output logic [CW-1:0] tx_conn,
  input  wire logic    tx_ready
);

  typedef struct packed {
    erg_pkg::erg_fmt_type st;
    erg_pkg::erg_msg_type kind;
    logic [CW-1:0]        conn;
    logic [4:0]           ev;
    logic                 has;
    logic                 val;
    logic [3:0]           step;
    logic                 txv;
    logic [7:0]           txd;
  } erg_fmt_state_type;

  erg_fmt_state_type r;
  erg_fmt_state_type n;
  logic [8:0]        cur;
  logic [8:0]        nxt;
  logic [8:0]        first;

  function automatic logic [7:0] hex_char(input logic [3:0] v);
    hex_char = (v < 4'hA) ? (erg_pkg::CH_ZERO + {4'h0, v}) : (8'h37 + {4'h0, v});
  endfunction

  // Returns {last, byte} for a message kind and step
  function automatic logic [8:0] byte_at(input erg_pkg::erg_msg_type k, input logic [3:0] s,
                                         input logic [4:0] ev, input logic has, input logic val);
    logic [4:0] tens;
    logic [4:0] ones;
    tens = (ev >= 5'd30) ? 5'd3 : (ev >= 5'd20) ? 5'd2 : (ev >= 5'd10) ? 5'd1 : 5'd0;
    ones = 5'(ev - 5'(tens * 5'd10));
    byte_at = {1'b1, erg_pkg::CH_LF};
    unique case (k)
      erg_pkg::ERG_MSG_OK:
        byte_at = (s == 4'h0) ? {1'b0, erg_pkg::CH_OK} : {1'b1, erg_pkg::CH_LF};
      erg_pkg::ERG_MSG_FAIL:
        case (s)
          4'h0:    byte_at = {1'b0, erg_pkg::CH_FAIL};
          4'h1:    byte_at = {1'b0, erg_pkg::CH_E};
          4'h2:    byte_at = {1'b0, erg_pkg::CH_R};
          4'h3:    byte_at = {1'b0, erg_pkg::CH_R};
          default: byte_at = {1'b1, erg_pkg::CH_LF};
        endcase
      erg_pkg::ERG_MSG_WELCOME:
        if (s < erg_pkg::WELCOME_LEN)
          byte_at = {1'b0, erg_pkg::WELCOME_TXT[8'(71 - 8 * s) -: 8]};
        else if (s < 4'hD)
          byte_at = {1'b0, hex_char(SERIAL_NUMBER[8'(15 - 4 * (s - erg_pkg::WELCOME_LEN)) -: 4])};
        else
          byte_at = {1'b1, erg_pkg::CH_LF};
      erg_pkg::ERG_MSG_EVENT:
        case (s)
          4'h0:    byte_at = {1'b0, erg_pkg::CH_AT};
          4'h1:    byte_at = {1'b0, 8'(erg_pkg::CH_ZERO + {3'h0, tens})};
          4'h2:    byte_at = {1'b0, 8'(erg_pkg::CH_ZERO + {3'h0, ones})};
          4'h3:    byte_at = has ? {1'b0, erg_pkg::CH_EQ} : {1'b1, erg_pkg::CH_LF};
          4'h4:    byte_at = {1'b0, 8'(erg_pkg::CH_ZERO + {7'h00, val})};
          default: byte_at = {1'b1, erg_pkg::CH_LF};
        endcase
      default: byte_at = {1'b1, erg_pkg::CH_LF};
    endcase
  endfunction

  always_comb
  begin
    n = r;
    cur = byte_at(r.kind, r.step, r.ev, r.has, r.val);
    nxt = byte_at(r.kind, 4'(r.step + 4'h1), r.ev, r.has, r.val);
    first = byte_at(msg.req_kind, 4'h0, msg.req_event, msg.req_has_value, msg.req_value);
    unique case (r.st)
      erg_pkg::ERG_F_IDLE:
        if (msg.req_valid)
        begin
          n.st = erg_pkg::ERG_F_SEND;
          n.kind = msg.req_kind;
          n.conn = msg.req_conn;
          n.ev = msg.req_event;
          n.has = msg.req_has_value;
          n.val = msg.req_value;
          n.step = 4'h0;
          n.txv = 1'b1;
          n.txd = first[7:0];
        end
      erg_pkg::ERG_F_SEND:
        if (tx_ready)
        begin
          if (cur[8])
          begin
            n.st = erg_pkg::ERG_F_IDLE;
            n.txv = 1'b0;
          end
          else
          begin
            n.step = 4'(r.step + 4'h1);
            n.txd = nxt[7:0];
          end
        end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.st <= erg_pkg::ERG_F_IDLE;
      r.kind <= erg_pkg::ERG_MSG_OK;
    end
    else
      r <= n;
  end

  assign msg.req_ready = (r.st == erg_pkg::ERG_F_IDLE);
  assign tx_valid = r.txv;
  assign tx_byte  = r.txd;
  assign tx_conn  = r.conn;

endmodule

/* design/erg_top.sv */
// Event report gate: command interpreter, per-connection enables, APB
// Functional notes
// - Greeting with serial number at boot, new session
// - Per-connection enables, cleared on connection open
// - Enable accepts several space-separated event names
// - All keyword enables every reportable condition
// - Valid enable answered with success and LF
// - Active ongoing-state condition reported at enable, then changes
// - Lamp events report one or zero per flash
// - Memory reported as empty, unsafe, safe, full
// - Disable turns off exactly the named events
// - Disable with All clears every enable
// - Valid disable answered with success and LF
// - Disable leaves parallel control outputs untouched
// - Events sent on serial and network connections
// - Every parallel condition is also reportable
// - Event line: at-sign, name, optional value, LF
// - Value suffix only on ongoing-state events
// - Requests end with LF; CR ignored
// - Bad request: failure character, message, LF, no action
`timescale 1ns/1ns
module erg_top #(
  parameter int          NCONN         = 2,
  parameter logic [15:0] SERIAL_NUMBER = 16'h0000,
  localparam int         CW            = $clog2(NCONN)
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [7:0]    paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               irq,
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_byte,
  input  wire logic [CW-1:0] rx_conn,
  output logic               rx_ready,
  input  wire logic [NCONN-1:0] conn_open,
  output logic               tx_valid,
  output logic      [7:0]    tx_byte,
  output logic      [CW-1:0] tx_conn,
  input  wire logic          tx_ready,
  input  wire logic          building,
  input  wire logic          grow_button_pressed,
  input  wire logic          bypass,
  input  wire logic [7:0]    cue_point_reached,
  input  wire logic [1:0]    memory_fill_code,
  input  wire logic          discard_button_pressed,
  input  wire logic          memory_just_emptied,
  input  wire logic          exiting,
  input  wire logic [7:0]    flag_point_reached,
  input  wire logic          memory_just_filled,
  input  wire logic          muted,
  input  wire logic          grow_lamp_state,
  input  wire logic          shrink_lamp_state,
  input  wire logic          discard_lamp_state,
  input  wire logic          brief_mute_lamp_state,
  output logic      [31:0]   cond_level
);

  localparam int NEV = erg_pkg::NEV;
  localparam int NB  = NCONN * NEV;

  typedef struct packed {
    logic                    pready;
    logic [31:0]             prdata;
    logic                    pslverr;
    logic [erg_pkg::IRQ_W-1:0] irq_en;
    logic [erg_pkg::IRQ_W-1:0] irq_stat;
    logic                    irq;
    logic [NB-1:0]           en;
    logic [NB-1:0]           pend;
    logic [NCONN-1:0]        welc;
    erg_pkg::erg_parse_type  pst;
    logic                    cmd_en;
    logic                    cmd_dis;
    logic                    bad;
    logic                    all;
    logic [NEV-1:0]          mask;
    logic [63:0]             tok;
    logic [3:0]              tlen;
    logic                    resp_valid;
    logic                    resp_ok;
    logic [CW-1:0]           resp_conn;
    logic                    rx_ready;
    logic                    req_valid;
    erg_pkg::erg_msg_type    req_kind;
    logic [CW-1:0]           req_conn;
    logic [4:0]              req_event;
    logic                    req_has;
    logic                    req_val;
  } erg_top_state_type;

  erg_top_state_type r;
  erg_top_state_type n;
  logic [NEV-1:0]    raw;
  logic [NEV-1:0]    lvl;
  logic [NEV-1:0]    chg;
  logic [NEV-1:0]    seen;
  logic [NEV-1:0]    sel;
  logic [NEV-1:0]    add;
  logic [7:0]        num;
  logic              take;
  logic              delim;
  logic              wr;
  logic [erg_pkg::IRQ_W-1:0] set_irq;
  logic [$clog2(NB)-1:0] pick;
  logic [CW-1:0]     pc;
  logic [4:0]        pe;

  erg_msg_if #(.CW(CW)) msg ();

  initial
  begin
    if (NCONN < 2 || NCONN > 8)
      $error("erg_top: NCONN must lie in 2..8");
  end

  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= erg_pkg::CH_ZERO) && (c <= erg_pkg::CH_NINE);
  endfunction

  function automatic logic [$clog2(NB)-1:0] first_set(input logic [NB-1:0] v);
    first_set = '0;
    for (int i = NB - 1; i >= 0; i--)
      if (v[i])
        first_set = ($clog2(NB))'(i);
  endfunction

  // Every parallel-output condition feeds the report vector
  always_comb
  begin
    raw = '0;
    raw[erg_pkg::EV_BUILDING] = building;
    raw[erg_pkg::EV_GROW_PRESS] = grow_button_pressed;
    raw[erg_pkg::EV_BYPASS] = bypass;
    raw[erg_pkg::EV_CUE0 +: 8] = cue_point_reached;
    raw[erg_pkg::EV_MEM_FULL:erg_pkg::EV_MEM_EMPTY] = memory_fill_code;
    raw[erg_pkg::EV_DISCARD_PRESS] = discard_button_pressed;
    raw[erg_pkg::EV_JUST_EMPTIED] = memory_just_emptied;
    raw[erg_pkg::EV_EXITING] = exiting;
    raw[erg_pkg::EV_FLAG0 +: 8] = flag_point_reached;
    raw[erg_pkg::EV_JUST_FILLED] = memory_just_filled;
    raw[erg_pkg::EV_MUTED] = muted;
    raw[erg_pkg::EV_LAMP0 +: 4] = {brief_mute_lamp_state, discard_lamp_state, shrink_lamp_state, grow_lamp_state};
  end

  erg_cond_sync #(.NEV(NEV)) u_sync (
    .pclk        (pclk),
    .presetn     (presetn),
    .cond_raw    (raw),
    .cond_level  (lvl),
    .cond_change (chg)
  );

  erg_fmt #(.CW(CW), .SERIAL_NUMBER(SERIAL_NUMBER)) u_fmt (
    .pclk     (pclk),
    .presetn  (presetn),
    .msg      (msg),
    .tx_valid (tx_valid),
    .tx_byte  (tx_byte),
    .tx_conn  (tx_conn),
    .tx_ready (tx_ready)
  );

  always_comb
  begin
    n = r;
    set_irq = '0;
    seen = '0;
    sel = '0;
    add = '0;
    num = 8'h00;
    pick = first_set(r.pend);
    pc = CW'(pick / NEV);
    pe = 5'(pick % NEV);

    // Request parser; CR dropped, LF or space ends a token
    take = rx_valid && r.rx_ready && (rx_byte != erg_pkg::CH_CR);
    delim = (rx_byte == erg_pkg::CH_SP) || (rx_byte == erg_pkg::CH_LF);
    if (take && !delim)
    begin
      n.tok = {r.tok[55:0], rx_byte};
      n.tlen = (r.tlen == 4'hF) ? r.tlen : 4'(r.tlen + 4'h1);
    end
    else if (take && r.tlen != 4'h0)
    begin
      n.tok = '0;
      n.tlen = 4'h0;
      if (r.pst == erg_pkg::ERG_P_CMD)
      begin
        n.pst = erg_pkg::ERG_P_ARG;
        n.cmd_en = (r.tlen == 4'h6) && (r.tok[47:0] == erg_pkg::KW_ENABLE);
        n.cmd_dis = (r.tlen == 4'h7) && (r.tok[55:0] == erg_pkg::KW_DISABLE);
        n.bad = !(n.cmd_en || n.cmd_dis);
      end
      else if (r.tlen == 4'h3 && (r.tok[23:0] == erg_pkg::KW_ALL_A || r.tok[23:0] == erg_pkg::KW_ALL_B))
        n.all = 1'b1;
      else
      begin
        // Event names: one or two decimal digits with a value below NEV; anything else spoils the line
        if (r.tlen == 4'h1 && is_digit(r.tok[7:0]))
          num = 8'(r.tok[7:0] - erg_pkg::CH_ZERO);
        else if (r.tlen == 4'h2 && is_digit(r.tok[7:0]) && is_digit(r.tok[15:8]))
          num = 8'((r.tok[15:8] - erg_pkg::CH_ZERO) * 8'h0A + (r.tok[7:0] - erg_pkg::CH_ZERO));
        else
          num = 8'hFF;
        if (num < 8'(NEV))
          n.mask = r.mask | (NEV'(1) << num[4:0]);
        else
          n.bad = 1'b1;
      end
    end
    if (take && rx_byte == erg_pkg::CH_LF)
    begin
      n.resp_valid = 1'b1;
      n.resp_conn = rx_conn;
      n.resp_ok = !n.bad && (n.cmd_en || n.cmd_dis) && (n.all || n.mask != '0);
      sel = n.all ? '1 : n.mask;
      seen = r.en[rx_conn * NEV +: NEV];
      // Only a fully valid line changes enables
      if (n.resp_ok && n.cmd_en)
      begin
        n.en[rx_conn * NEV +: NEV] = seen | sel;
        add = sel & ~seen & lvl & ~erg_pkg::MOMENTARY_MASK;
      end
      else if (n.resp_ok && n.cmd_dis)
        n.en[rx_conn * NEV +: NEV] = seen & ~sel;
      n.pst = erg_pkg::ERG_P_CMD;
      n.cmd_en = 1'b0;
      n.cmd_dis = 1'b0;
      n.bad = 1'b0;
      n.all = 1'b0;
      n.mask = '0;
      n.tok = '0;
      n.tlen = 4'h0;
    end

    // Formatter handshake and issue: greeting, then result, then events
    if (r.req_valid && msg.req_ready)
      n.req_valid = 1'b0;
    if (!r.req_valid)
    begin
      if (r.welc != '0)
      begin
        n.req_valid = 1'b1;
        n.req_kind = erg_pkg::ERG_MSG_WELCOME;
        n.req_conn = CW'(first_set({{(NB - NCONN){1'b0}}, r.welc}));
        n.welc[n.req_conn] = 1'b0;
        set_irq[erg_pkg::IRQ_WELCOME] = 1'b1;
      end
      else if (r.resp_valid)
      begin
        n.req_valid = 1'b1;
        n.req_kind = r.resp_ok ? erg_pkg::ERG_MSG_OK : erg_pkg::ERG_MSG_FAIL;
        n.req_conn = r.resp_conn;
        n.resp_valid = 1'b0;
        set_irq[r.resp_ok ? erg_pkg::IRQ_ACCEPT : erg_pkg::IRQ_REJECT] = 1'b1;
      end
      else if (r.pend != '0)
      begin
        n.req_valid = 1'b1;
        n.req_kind = erg_pkg::ERG_MSG_EVENT;
        n.req_conn = pc;
        n.req_event = pe;
        n.req_has = !erg_pkg::MOMENTARY_MASK[pe];
        n.req_val = lvl[pe];
        n.pend[pick] = 1'b0;
        set_irq[erg_pkg::IRQ_REPORT] = 1'b1;
      end
    end
    n.rx_ready = !n.resp_valid;

    // Pending reports: new sets win over the clear above
    for (int c = 0; c < NCONN; c++)
    begin
      if (c == int'(rx_conn))
        n.pend[c * NEV +: NEV] = n.pend[c * NEV +: NEV] | add;
      n.pend[c * NEV +: NEV] = n.pend[c * NEV +: NEV] | (chg & r.en[c * NEV +: NEV]);
      if (conn_open[c])
      begin
        n.en[c * NEV +: NEV] = '0;
        n.pend[c * NEV +: NEV] = '0;
        n.welc[c] = 1'b1;
      end
    end

    // APB slave: zero wait states, decode in setup cycle
    wr = psel && penable && r.pready && pwrite;
    n.pready = psel && !penable;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (psel && !penable)
    begin
      if (paddr == erg_pkg::OFS_IRQ_STATUS)
        n.prdata = 32'(r.irq_stat);
      else if (paddr == erg_pkg::OFS_IRQ_ENABLE)
        n.prdata = 32'(r.irq_en);
      else if (paddr == erg_pkg::OFS_IRQ_CLEAR)
        n.prdata = 32'h0000_0000;
      else if (paddr == erg_pkg::OFS_COND_STATE)
        n.prdata = lvl;
      else if (paddr >= erg_pkg::OFS_CONN_BASE && paddr[1:0] == 2'h0
               && (paddr - erg_pkg::OFS_CONN_BASE) < 8'(4 * NCONN))
        n.prdata = r.en[(int'(paddr - erg_pkg::OFS_CONN_BASE) / 4) * NEV +: NEV];
      else
        n.pslverr = 1'b1;
    end
    if (wr && paddr == erg_pkg::OFS_IRQ_ENABLE)
      n.irq_en = pwdata[erg_pkg::IRQ_W-1:0];
    if (wr && paddr == erg_pkg::OFS_IRQ_CLEAR)
      n.irq_stat = r.irq_stat & ~pwdata[erg_pkg::IRQ_W-1:0];
    n.irq_stat = n.irq_stat | set_irq;
    n.irq = |(n.irq_stat & n.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.irq_en <= erg_pkg::IRQ_EN_RESET;
      r.welc <= '1;
      r.pst <= erg_pkg::ERG_P_CMD;
      r.rx_ready <= 1'b1;
      r.req_kind <= erg_pkg::ERG_MSG_OK;
    end
    else
      r <= n;
  end

  assign msg.req_valid     = r.req_valid;
  assign msg.req_kind      = r.req_kind;
  assign msg.req_conn      = r.req_conn;
  assign msg.req_event     = r.req_event;
  assign msg.req_has_value = r.req_has;
  assign msg.req_value     = r.req_val;

  assign prdata     = r.prdata;
  assign pready     = r.pready;
  assign pslverr    = r.pslverr;
  assign irq        = r.irq;
  assign rx_ready   = r.rx_ready;
  // Parallel feed runs regardless of report enables
  assign cond_level = lvl;

endmodule

/* testbench/erg_top_properties.sv */
// Port-level checks of the event report gate
`timescale 1ns/1ns
module erg_top_properties #(
  parameter int  NCONN = 2,
  localparam int CW    = $clog2(NCONN)
) (
  input wire logic          pclk, presetn, psel, penable, pready, pslverr,
  input wire logic          rx_valid, rx_ready, tx_valid, tx_ready, muted,
  input wire logic [7:0]    rx_byte, tx_byte,
  input wire logic [CW-1:0] tx_conn,
  input wire logic [1:0]    memory_fill_code,
  input wire logic [31:0]   cond_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_lf_in;
    rx_valid && rx_ready && rx_byte == erg_pkg::CH_LF;
  endsequence
  sequence s_ok_out;
    tx_valid && tx_ready && tx_byte == erg_pkg::CH_OK;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready && penable) else $error("no access answer");
  a_ready_one_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_tx_held_stall: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_conn))
    else $error("tx byte dropped");
  a_rx_stop_lf: assert property (s_lf_in |=> !rx_ready) else $error("rx not held");
  a_ok_then_lf: assert property (s_ok_out |=> !tx_valid || tx_byte == erg_pkg::CH_LF)
    else $error("no LF after ok");
  a_line_start: assert property ($rose(tx_valid) |-> tx_byte inside {8'h40, 8'h21, 8'h3F})
    else $error("bad line start");
  a_fill_empty: assert property ((memory_fill_code == 2'h0) [*6] |-> cond_level[11] && !cond_level[14])
    else $error("empty level wrong");
  a_mute_level: assert property (muted [*6] |-> cond_level[27])
    else $error("muted level lost");
endmodule
bind erg_top erg_top_properties #(.NCONN(NCONN)) u_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .rx_valid, .rx_ready, .tx_valid, .tx_ready, .muted, .rx_byte, .tx_byte, .tx_conn, .memory_fill_code, .cond_level);

/* testbench/erg_host_model.sv */
// Remote controller model: sends request lines, collects reply bytes
`timescale 1ns/1ns
module erg_host_model #(
  parameter int CW = 1
) (
  input wire logic           pclk, rx_ready, tx_valid,
  input wire logic [7:0]     tx_byte,
  output logic               rx_valid = 1'b0,
  output logic               tx_ready = 1'b0,
  output logic [7:0]         rx_byte = 8'h00,
  output logic [CW-1:0]      rx_conn = '0
);
  logic [7:0] q[$];
  logic [1:0] slow = 2'h0;
  logic       stuck = 1'b0;
  // Reply sink stalls one cycle in four
  always @(posedge pclk)
  begin
    if (tx_valid && tx_ready)
      q.push_back(tx_byte);
    slow <= slow + 2'h1;
    tx_ready <= slow != 2'h3;
  end
  // Words split by spaces, line closed by LF
  task automatic send_line(input string s, input logic [CW-1:0] c);
    int n;
    foreach (s[i])
    begin
      rx_valid <= 1'b1;
      rx_byte <= s[i];
      rx_conn <= c;
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (rx_ready !== 1'b1 && n < 200);
      if (n >= 200)
        stuck = 1'b1;
    end
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench of the event report gate
`timescale 1ns/1ns
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic        pready, pslverr, irq, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [0:0]  rx_conn, tx_conn;
  logic [7:0]  paddr = 8'h00, rx_byte, tx_byte;
  logic [31:0] pwdata = 32'h0, prdata, cond_level, r, cnd = 32'h0;
  logic [1:0]  fill = 2'h0, opn = 2'h0;
  logic [3:0]  lv[4] = '{4'h1, 4'h8, 4'h4, 4'h6};
  int          err_count = 0, n_compared = 0;
  typedef struct {string cmd; logic c; logic [7:0] res;} erg_row_type;
  erg_row_type rows[6] = '{'{"enable 2 13\n", 0, 8'h21}, '{"enable 12 77\n", 0, 8'h3F}, '{"bogus 2\n", 1, 8'h3F},
    '{"disable 13\n", 0, 8'h21}, '{"enable 29\r\n", 1, 8'h21}, '{"enable\n", 0, 8'h3F}};
  erg_top #(.NCONN(2), .SERIAL_NUMBER(16'h3A5C)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .irq, .rx_valid, .rx_byte, .rx_conn, .rx_ready, .conn_open(opn), .tx_valid,
    .tx_byte, .tx_conn, .tx_ready, .building(cnd[0]), .grow_button_pressed(cnd[1]), .bypass(cnd[2]),
    .cue_point_reached(cnd[10:3]), .memory_fill_code(fill), .discard_button_pressed(cnd[15]),
    .memory_just_emptied(cnd[16]), .exiting(cnd[17]), .flag_point_reached(cnd[25:18]),
    .memory_just_filled(cnd[26]), .muted(cnd[27]), .grow_lamp_state(cnd[28]), .shrink_lamp_state(cnd[29]),
    .discard_lamp_state(cnd[30]), .brief_mute_lamp_state(cnd[31]), .cond_level);
  erg_host_model u_host (.pclk, .rx_ready, .tx_valid, .tx_byte, .rx_valid, .tx_ready, .rx_byte, .rx_conn);
  initial forever #10 pclk = ~pclk;
  task automatic check(input string nm, input logic [31:0] x, input logic [31:0] got);
    n_compared++;
    if (got !== x)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, got);
    end
  endtask
  task automatic qb(input int i, input logic [7:0] x);
    check($sformatf("byte %0d", i), x, u_host.q[i]);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic hung(input int n);
    if (n >= 3000)
    begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic wait_q(input int k);
    int n;
    for (n = 0; u_host.q.size() < k && n < 3000; n++)
      @(posedge pclk);
    hung(n);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n == 0 || (pready !== 1'b1 && n < 3000); n++)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    hung(n);
  endtask
  task automatic line(input string s, input int k);
    u_host.q.delete();
    u_host.send_line(s, 1'b0);
    wait_q(k);
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_q(28);
    qb(0, "@");
    qb(9, "3");
    qb(27, 8'h0A);
    apb(1'b1, erg_pkg::OFS_IRQ_ENABLE, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", 1, e);
    $display("test boot done");
    foreach (rows[i])
    begin
      u_host.q.delete();
      u_host.send_line(rows[i].cmd, rows[i].c);
      wait_q(rows[i].res == 8'h21 ? 2 : 5);
      qb(0, rows[i].res);
    end
    apb(1'b0, erg_pkg::OFS_CONN_BASE, 0);
    check("enables conn0", 32'h4, r);
    apb(1'b0, erg_pkg::OFS_CONN_BASE + 8'h4, 0);
    check("enables conn1", 32'h20000000, r);
    check("irq raised", 1, irq);
    apb(1'b1, erg_pkg::OFS_IRQ_CLEAR, 32'hF);
    apb(1'b0, erg_pkg::OFS_IRQ_STATUS, 0);
    check("irq cleared", 0, irq);
    $display("test table done");
    line("enable All\n", 8);
    qb(3, "1");
    qb(6, "1");
    u_host.q.delete();
    opn <= 2'b01;
    @(posedge pclk);
    opn <= 2'b00;
    wait_q(14);
    qb(0, "@");
    apb(1'b0, erg_pkg::OFS_CONN_BASE, 0);
    check("enables reopened", 0, r);
    cnd[28:27] <= 2'h3;
    line("enable 27 28\n", 14);
    qb(4, "7");
    qb(12, "1");
    u_host.q.delete();
    cnd[28] <= 1'b0;
    wait_q(6);
    qb(4, "0");
    line("disable ALL\n", 2);
    apb(1'b0, erg_pkg::OFS_CONN_BASE, 0);
    check("enables cleared", 0, r);
    foreach (lv[k])
    begin
      fill <= k[1:0];
      repeat (6) @(posedge pclk);
      check("memory levels", lv[k], cond_level[14:11]);
    end
    check("host stall", 0, u_host.stuck);
    $display("test events done");
    report_and_stop();
  end
endmodule
